/* src/bjb_defs.svh */
// bit positions, widths and reset values of the bus to jtag bridge
`ifndef BJB_DEFS_SVH
`define BJB_DEFS_SVH

// width of the processor data bus
`define BJB_DATA_W    4

// data bus bit positions
`define BJB_BIT_TCK   0
`define BJB_BIT_TMS   1
`define BJB_BIT_TDI   2
`define BJB_BIT_TDO   3

// reset values of the chain drive registers
`define BJB_RST_TCK   1'b0
`define BJB_RST_TMS   1'b1
`define BJB_RST_TDI   1'b0

// default chain address on the processor bus
`define BJB_CHAIN_ADDR_DEF 8'h00
`define BJB_ADDR_W_DEF     8

`endif

/* src/bjb_pkg.sv */
// types shared by the bus to jtag bridge
`default_nettype none
package bjb_pkg;

  // the three lines that drive the scan chain
  typedef struct packed {
    logic tdi;
    logic tms;
    logic tck;
  } bjb_jtag_t;

endpackage
`default_nettype wire

/* src/bjb_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module bjb_sync
#(
  parameter int unsigned W = 1
)
(
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // asynchronous levels in, synchronous levels out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta;

  if (W < 1)
  begin : g_chk
    $error("bjb_sync needs at least one bit");
  end

  // first stage is read only by the second
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta <= '0;
      o_q  <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule // bjb_sync
`default_nettype wire

/* src/bjb_bridge.sv */
// bus to jtag bridge: bus decode, chain drive registers and cable mux
`timescale 1ns/100ps
`default_nettype none
`include "bjb_defs.svh"
module bjb_bridge
#(
  parameter int unsigned       ADDR_W      = `BJB_ADDR_W_DEF,
  parameter logic [ADDR_W-1:0] CHAIN_ADDR  = `BJB_CHAIN_ADDR_DEF,
  parameter bit                USE_DECODE  = 1'b1,
  parameter bit                READBACK_EN = 1'b1
)
(
  // system clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_b,
  // link clock of the cable side
  input  wire logic                    i_link_clk,
  // processor bus
  input  wire logic [ADDR_W-1:0]       i_addr,
  input  wire logic                    i_read_not_write,
  input  wire logic                    i_access_strobe,
  input  wire logic [`BJB_DATA_W-1:0]  i_data,
  output logic      [`BJB_DATA_W-1:0]  o_data,
  output logic                         o_data_oe,
  // scan chain
  output var bjb_pkg::bjb_jtag_t       o_jtag,
  input  wire logic                    i_chain_tdo,
  // download cable header
  input  wire bjb_pkg::bjb_jtag_t      i_cable,
  input  wire logic                    i_cable_sel,
  output logic                         o_cable_tdo
);

  localparam int unsigned SYNC_W = $bits(bjb_pkg::bjb_jtag_t) + 2;

  localparam bjb_pkg::bjb_jtag_t RST_JTAG = '{
    tdi: `BJB_RST_TDI,
    tms: `BJB_RST_TMS,
    tck: `BJB_RST_TCK
  };

  if (ADDR_W < 1 || ADDR_W > 32)
  begin : g_chk
    $error("bjb_bridge address width must be 1 to 32");
  end

  logic [SYNC_W-1:0]              sync_q;
  logic                           cable_sel_s;
  bjb_pkg::bjb_jtag_t             cable_s;
  logic                           tdo_s;
  logic                           tdo_link;
  logic                           qual;
  logic                           wr_hit;
  logic                           rd_hit;
  bjb_pkg::bjb_jtag_t             proc_jtag;
  logic [`BJB_DATA_W-1:0]         next_rdata;

  // cable and chain pins into the system domain
  bjb_sync
  #(
    .W (SYNC_W)
  )
  u_sync_sys
  (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     ({i_cable_sel, i_cable, i_chain_tdo}),
    .o_q     (sync_q)
  );

  assign cable_sel_s = sync_q[SYNC_W-1];
  assign cable_s     = bjb_pkg::bjb_jtag_t'(sync_q[SYNC_W-2:1]);
  assign tdo_s       = sync_q[0];

  // chain data-out into the link domain
  bjb_sync
  #(
    .W (1)
  )
  u_sync_link
  (
    .i_clk   (i_link_clk),
    .i_rst_b (i_rst_b),
    .i_d     (i_chain_tdo),
    .o_q     (tdo_link)
  );

  // cable sees the chain data-out unchanged
  always_ff @(posedge i_link_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_cable_tdo <= 1'b0;
    else
      o_cable_tdo <= tdo_link;
  end

  // access qualification
  always_comb
  begin
    if (USE_DECODE)
      qual = i_access_strobe && (i_addr == CHAIN_ADDR);
    else
      qual = i_access_strobe;
  end

  assign wr_hit = qual && !i_read_not_write;
  assign rd_hit = qual && i_read_not_write;

  // processor drive registers
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      proc_jtag <= RST_JTAG;
    else if (wr_hit)
    begin
      proc_jtag.tck <= i_data[`BJB_BIT_TCK];
      proc_jtag.tms <= i_data[`BJB_BIT_TMS];
      proc_jtag.tdi <= i_data[`BJB_BIT_TDI];
    end
  end

  // chain output mux, registered
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_jtag <= RST_JTAG;
    else if (cable_sel_s)
      o_jtag <= cable_s;
    else
      o_jtag <= proc_jtag;
  end

  // read data
  always_comb
  begin
    next_rdata = '0;
    next_rdata[`BJB_BIT_TDO] = tdo_s;
    if (READBACK_EN)
    begin
      next_rdata[`BJB_BIT_TCK] = proc_jtag.tck;
      next_rdata[`BJB_BIT_TMS] = proc_jtag.tms;
      next_rdata[`BJB_BIT_TDI] = proc_jtag.tdi;
    end
  end

  // bus drivers enabled only in answer to a read
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_data_oe <= 1'b0;
      o_data    <= '0;
    end
    else
    begin
      o_data_oe <= rd_hit;
      if (rd_hit)
        o_data <= next_rdata;
      else
        o_data <= '0;
    end
  end

  // checks
  sequence s_wr_hit;
    i_access_strobe && !i_read_not_write
      && (!USE_DECODE || i_addr == CHAIN_ADDR);
  endsequence

  sequence s_rd_hit;
    i_access_strobe && i_read_not_write
      && (!USE_DECODE || i_addr == CHAIN_ADDR);
  endsequence

  a_write_capture: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    s_wr_hit |=> proc_jtag.tck == $past(i_data[`BJB_BIT_TCK])
      && proc_jtag.tms == $past(i_data[`BJB_BIT_TMS])
      && proc_jtag.tdi == $past(i_data[`BJB_BIT_TDI]))
    else $error("write did not load the chain registers");

  a_ignore_unqual: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !wr_hit |=> $stable(proc_jtag))
    else $error("chain registers changed without a qualified write");

  a_write_to_pin: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (s_wr_hit ##1 !cable_sel_s)
      |=> o_jtag.tck == $past(i_data[`BJB_BIT_TCK], 2))
    else $error("written tck did not reach the chain");

  a_read_drive: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    s_rd_hit |=> o_data_oe && o_data[`BJB_BIT_TDO] == $past(tdo_s))
    else $error("read did not return chain data-out");

  a_bus_release: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !rd_hit |=> !o_data_oe && o_data == '0)
    else $error("bus driven outside a read");

  a_read_back: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (READBACK_EN && rd_hit) |=> o_data[`BJB_BIT_TDI] == $past(proc_jtag.tdi)
      && o_data[`BJB_BIT_TMS] == $past(proc_jtag.tms)
      && o_data[`BJB_BIT_TCK] == $past(proc_jtag.tck))
    else $error("read back mismatch");

  a_cable_pass: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cable_sel_s |=> o_jtag == $past(cable_s))
    else $error("cable signals not forwarded");

  a_cable_block: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (cable_sel_s && wr_hit) |=> o_jtag == $past(cable_s)
      && proc_jtag.tms == $past(i_data[`BJB_BIT_TMS]))
    else $error("write under cable select handled wrongly");

  a_proc_drive: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !cable_sel_s [*2] |-> o_jtag == $past(proc_jtag))
    else $error("chain not driven from processor registers");

  a_cable_tdo: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_b)
    $rose(tdo_link) |=> o_cable_tdo)
    else $error("cable data-out not forwarded");

endmodule // bjb_bridge
`default_nettype wire

/* test/bjb_chain_model.sv */
// scan chain model: one capture stage from tdi to tdo
`timescale 1ns/100ps
`default_nettype none
module bjb_chain_model
(
  // chain pins
  input  wire bjb_pkg::bjb_jtag_t i_jtag,
  output logic                    o_tdo
);
  initial o_tdo = 1'b0;
  // capture tdi on the rising test clock
  always @(posedge i_jtag.tck)
    o_tdo <= i_jtag.tdi;
endmodule // bjb_chain_model
`default_nettype wire

/* test/tb_bus_to_jtag_bridge.sv */
// self-checking bench of the bus to jtag bridge
`timescale 1ns/100ps
`default_nettype none
module tb_bus_to_jtag_bridge;
  logic               clk, rst_b, lclk, rnw, stb, sel, oe, ctdo, tdo;
  logic [7:0]         addr;
  logic [3:0]         wd, rd;
  bjb_pkg::bjb_jtag_t jt, cab;
  int                 err_count, n_checks, cyc;
  logic               oe2;
  logic [3:0]         rd2;
  bjb_pkg::bjb_jtag_t jt2;

  bjb_bridge dut (.i_clk(clk), .i_rst_b(rst_b), .i_link_clk(lclk),
    .i_addr(addr), .i_read_not_write(rnw), .i_access_strobe(stb),
    .i_data(wd), .o_data(rd), .o_data_oe(oe), .o_jtag(jt),
    .i_chain_tdo(tdo), .i_cable(cab), .i_cable_sel(sel),
    .o_cable_tdo(ctdo));
  bjb_chain_model chain (.i_jtag(jt), .o_tdo(tdo));
  // second bridge without address decode or read-back
  bjb_bridge #(.USE_DECODE(1'b0), .READBACK_EN(1'b0)) dut_min (.i_clk(clk),
    .i_rst_b(rst_b), .i_link_clk(lclk), .i_addr(addr),
    .i_read_not_write(rnw), .i_access_strobe(stb), .i_data(wd),
    .o_data(rd2), .o_data_oe(oe2), .o_jtag(jt2), .i_chain_tdo(tdo),
    .i_cable(cab), .i_cable_sel(sel), .o_cable_tdo());

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end

  task automatic chk_jtag(string n, logic [2:0] e, logic [2:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_val(string n, logic [3:0] e, logic [3:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one strobed access, released at the edge that takes it
  task automatic bus(logic r, logic [7:0] a, logic [3:0] d);
    @(posedge clk);
    rnw  <= r;
    addr <= a;
    wd   <= d;
    stb  <= 1'b1;
    @(posedge clk);
    stb  <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(logic [3:0] e);
    bus(1'b1, 8'h00, 4'h0);
    chk_val("read oe", 4'h1, {3'h0, oe});
    chk_val("read data", e, rd);
    tick(1);
    chk_val("oe after read", 4'h1, {3'h0, ~oe});
  endtask

  task automatic t_reset;
    chk_jtag("reset jtag", 3'b010, jt);
    chk_val("reset oe", 4'h0, {3'h0, oe});
    chk_val("reset data", 4'h0, rd);
    chk_val("reset cable tdo", 4'h0, {3'h0, ctdo});
  endtask
  task automatic t_write;
    logic [2:0] prev;
    prev = 3'b010;
    for (int v = 0; v < 8; v++)
    begin
      bus(1'b0, 8'h00, v[3:0]);
      chk_jtag("jtag before", prev, jt);
      tick(1);
      chk_jtag("jtag after", v[2:0], jt);
      prev = v[2:0];
    end
  endtask
  task automatic t_read;
    bus(1'b0, 8'h00, 4'h0);
    bus(1'b0, 8'h00, 4'h5);
    tick(4);
    rd_chk(4'hd);
    bus(1'b0, 8'h00, 4'h0);
    bus(1'b0, 8'h00, 4'h1);
    tick(4);
    rd_chk(4'h1);
  endtask
  task automatic t_decode;
    bus(1'b0, 8'h01, 4'h6);
    tick(2);
    chk_jtag("foreign write", 3'b001, jt);
    chk_jtag("undecoded write", 3'b110, jt2);
    bus(1'b1, 8'h01, 4'h0);
    chk_val("foreign read", 4'h0, {3'h0, oe});
    chk_val("undecoded oe", 4'h1, {3'h0, oe2});
    chk_val("undecoded data", 4'h0, rd2);
  endtask
  task automatic t_cable;
    @(posedge clk);
    cab <= 3'b100;
    sel <= 1'b1;
    tick(5);
    chk_jtag("cable drive", 3'b100, jt);
    @(posedge clk);
    cab <= 3'b101;
    tick(40);
    chk_val("cable tdo", 4'h1, {3'h0, ctdo});
    rd_chk(4'h9);
    bus(1'b0, 8'h00, 4'h2);
    tick(3);
    chk_jtag("write hidden", 3'b101, jt);
    rd_chk(4'ha);
    @(posedge clk);
    sel <= 1'b0;
    tick(5);
    chk_jtag("stored drive", 3'b010, jt);
  endtask
  task automatic t_rerun;
    bus(1'b0, 8'h00, 4'h5);
    tick(2);
    chk_jtag("before reset", 3'b101, jt);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    t_reset;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      finish_test;
    end
  end

  initial
  begin
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    rst_b = 1'b0;
    rnw = 1'b0;
    stb = 1'b0;
    sel = 1'b0;
    addr = 8'h00;
    wd = 4'h0;
    cab = 3'b000;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    t_reset;
    t_write;
    t_read;
    t_decode;
    t_cable;
    t_rerun;
    finish_test;
  end
endmodule // tb_bus_to_jtag_bridge
`default_nettype wire
